// File: hdl/dihc_top.sv
/*
  Interrupt source flags and primary line control register of a line
  interface: sticky event flags, interrupt pin, ring indicator, hook control.
  Assumes line-side levels arrive asynchronously, mask and control bits come
  from other registers on ref_clk, and a single-cycle register port.
*/
`timescale 1ns/1ps
`include "dihc_map.svh"

module dihc_top
#(
  parameter int RING_HOLD_CYCLES = `DIHC_RING_HOLD_S * `DIHC_CLK_HZ
)
(
  // Clock and reset
  input  wire logic                ref_clk,
  input  wire logic                resetn,
  // Host register port
  input  wire logic [7:0]          reg_addr,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  input  wire dihc_pkg::dihc_byte_t reg_wdata,
  output dihc_pkg::dihc_byte_t     reg_rdata,
  // Configuration from neighbouring registers
  input  wire dihc_pkg::dihc_byte_t irq_mask,
  input  wire logic                global_irq_enable,
  input  wire logic                ring_irq_mode,
  input  wire logic                full_wave_ring_enable,
  input  wire logic                irq_polarity_select,
  input  wire logic                watchdog_expired,
  // Line-side status levels, asynchronous
  input  wire logic                ring_positive_in,
  input  wire logic                ring_negative_in,
  input  wire logic                rx_overload_in,
  input  wire logic                frame_lock_in,
  input  wire logic                billing_tone_in,
  input  wire logic                dropout_status_in,
  input  wire logic                tip_ground_status_in,
  input  wire logic                line_voltage_msb_in,
  input  wire logic [4:0]          loop_current_reading_in,
  // Outputs
  output logic                     irq_output_pin,
  output logic                     offhook_control,
  output logic                     onhook_monitor_enable,
  output logic                     ring_indicator,
  output logic                     rx_overload_status_clear,
  output dihc_pkg::dihc_byte_t     irq_flags
);

  localparam int CNT_W = $clog2(RING_HOLD_CYCLES + 1);
  localparam logic [CNT_W-1:0] HOLD_LOAD = CNT_W'(RING_HOLD_CYCLES - 1);
  localparam int SYNC_W = 13;
  // Lock and tip ground status idle high so reset does not fake events
  localparam logic [SYNC_W-1:0] SYNC_RST = 13'h0240;

  // Synchronised line-side levels
  logic [SYNC_W-1:0]        sync_vec;
  logic                     ring_pos_s;
  logic                     ring_neg_s;
  logic                     rx_ovl_s;
  logic                     lock_s;
  logic                     billing_s;
  logic                     dropout_s;
  logic                     tip_gnd_s;
  logic                     lvs_msb_s;
  logic [4:0]               loop_s;

  // Edge history
  logic                     billing_prev;
  logic                     dropout_prev;
  logic                     lvs_prev;

  // Ring indicator machine
  dihc_pkg::dihc_ring_state_t ring_state;
  dihc_pkg::dihc_ring_state_t next_ring_state;
  logic [CNT_W-1:0]         hold_cnt;
  logic [CNT_W-1:0]         next_hold_cnt;

  // Decode and event wires
  logic                     wr_src;
  logic                     wr_ctl;
  logic                     rd_src;
  logic                     rd_ctl;
  logic                     ring_qual;
  logic                     offhook_rise;
  logic                     next_offhook;
  logic                     ri_rise;
  logic                     ri_fall;
  logic [7:0]               flag_set;
  logic [7:0]               flag_clr;
  logic [7:0]               next_flags;
  logic                     irq_active;
  dihc_pkg::dihc_byte_t     ctl_view;
  dihc_pkg::dihc_byte_t     next_rdata;

  // Line-side levels cross into ref_clk
  dihc_sync
  #(
    .WIDTH     (SYNC_W),
    .RESET_VAL (SYNC_RST)
  )
  u_sync
  (
    .ref_clk  (ref_clk),
    .resetn   (resetn),
    .async_in ({ring_positive_in, ring_negative_in, rx_overload_in, frame_lock_in,
                billing_tone_in, dropout_status_in, tip_ground_status_in,
                line_voltage_msb_in, loop_current_reading_in}),
    .sync_out (sync_vec)
  );

  // Unpack synchronised vector; loop reading bits are not coherent
  assign {ring_pos_s, ring_neg_s, rx_ovl_s, lock_s, billing_s, dropout_s,
          tip_gnd_s, lvs_msb_s, loop_s} = sync_vec;

  // Register port decode
  assign wr_src = reg_wr && (reg_addr == `DIHC_REG_IRQ_SRC);
  assign wr_ctl = reg_wr && (reg_addr == `DIHC_REG_LINE_CTL);
  assign rd_src = reg_rd && (reg_addr == `DIHC_REG_IRQ_SRC);
  assign rd_ctl = reg_rd && (reg_addr == `DIHC_REG_LINE_CTL);

  // off-hook command
  // Watchdog expiry overrides a write in the same cycle
  assign next_offhook = watchdog_expired ? 1'b0 :
                        wr_ctl ? reg_wdata[`DIHC_CTL_OFFHOOK] : offhook_control;
  assign offhook_rise = next_offhook && !offhook_control;

  assign ring_qual = ring_pos_s || (full_wave_ring_enable && ring_neg_s);

  // ring indicator hold and off-hook clear
  always_comb
  begin
    next_ring_state = ring_state;
    next_hold_cnt   = hold_cnt;
    unique case (ring_state)
      dihc_pkg::DIHC_RI_IDLE:
      begin
        if (ring_qual && !offhook_rise)
        begin
          next_ring_state = dihc_pkg::DIHC_RI_RINGING;
          next_hold_cnt   = HOLD_LOAD;
        end
      end
      dihc_pkg::DIHC_RI_RINGING:
      begin
        if (offhook_rise)
          next_ring_state = dihc_pkg::DIHC_RI_IDLE;
        else if (ring_qual)
          next_hold_cnt = HOLD_LOAD;
        else if (hold_cnt == '0)
          next_ring_state = dihc_pkg::DIHC_RI_IDLE;
        else
          next_hold_cnt = hold_cnt - CNT_W'(1);
      end
    endcase
  end

  assign ri_rise = (next_ring_state == dihc_pkg::DIHC_RI_RINGING) && !ring_indicator;
  assign ri_fall = (next_ring_state == dihc_pkg::DIHC_RI_IDLE) && ring_indicator;

  // Hardware set terms per flag
  always_comb
  begin
    flag_set = 8'h00;
    // ring start, and end in two-interrupt mode
    flag_set[`DIHC_BIT_RING]     = ri_rise || (ring_irq_mode && ri_fall);
    flag_set[`DIHC_BIT_RX_OVL]   = rx_ovl_s;
    flag_set[`DIHC_BIT_FRAME]    = !lock_s;
    flag_set[`DIHC_BIT_BILLING]  = billing_s && !billing_prev;
    flag_set[`DIHC_BIT_DROPOUT]  = dropout_s && !dropout_prev;
    flag_set[`DIHC_BIT_LOOP_SAT] = (loop_s == `DIHC_LOOP_MAX);
    flag_set[`DIHC_BIT_TIP_GND]  = !tip_gnd_s;
    flag_set[`DIHC_BIT_POLARITY] = lvs_msb_s != lvs_prev;
  end

  // write zero clears, set wins over clear
  assign flag_clr   = wr_src ? ~reg_wdata : 8'h00;
  assign next_flags = (irq_flags & ~flag_clr) | flag_set;

  // masked OR gated by the global enable
  assign irq_active = global_irq_enable && |(next_flags & irq_mask);

  // Line control read view with reserved bits zero
  // live ring status
  always_comb
  begin
    ctl_view                     = 8'h00;
    ctl_view[`DIHC_CTL_RING_NEG] = ring_neg_s;
    ctl_view[`DIHC_CTL_RING_POS] = ring_pos_s;
    ctl_view[`DIHC_CTL_ONHOOK_MONITOR_ENABLE]     = onhook_monitor_enable;
    ctl_view[`DIHC_CTL_RING_IND] = ring_indicator;
    ctl_view[`DIHC_CTL_OFFHOOK]  = offhook_control;
  end

  assign next_rdata = rd_src ? irq_flags : rd_ctl ? ctl_view : 8'h00;

  // Flags, edge history, read data and overload mirror clear
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      irq_flags                <= `DIHC_IRQ_SRC_RESET;
      billing_prev             <= 1'b0;
      dropout_prev             <= 1'b0;
      lvs_prev                 <= 1'b0;
      reg_rdata                <= 8'h00;
      rx_overload_status_clear <= 1'b0;
    end
    else
    begin
      irq_flags    <= next_flags;
      billing_prev <= billing_s;
      dropout_prev <= dropout_s;
      lvs_prev     <= lvs_msb_s;
      reg_rdata    <= next_rdata;
      // mirror clear pulse on bit 6 zero write
      rx_overload_status_clear <= flag_clr[`DIHC_BIT_RX_OVL];
    end
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      offhook_control       <= 1'(`DIHC_LINE_CTL_RESET >> `DIHC_CTL_OFFHOOK);
      onhook_monitor_enable <= 1'b0;
    end
    else
    begin
      offhook_control <= next_offhook;
      if (wr_ctl)
        onhook_monitor_enable <= reg_wdata[`DIHC_CTL_ONHOOK_MONITOR_ENABLE];
    end
  end

  // Ring indicator machine state
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ring_state <= dihc_pkg::DIHC_RI_IDLE;
      hold_cnt   <= '0;
    end
    else
    begin
      ring_state <= next_ring_state;
      hold_cnt   <= next_hold_cnt;
    end
  end

  assign ring_indicator = (ring_state == dihc_pkg::DIHC_RI_RINGING);

  // interrupt pin polarity, idle high out of reset
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      irq_output_pin <= 1'b1;
    else
      irq_output_pin <= irq_polarity_select ? irq_active : !irq_active;
  end

  // Flags only fall through a zero write
  chk_flags_sticky: assert property (@(posedge ref_clk) disable iff (!resetn)
    !wr_src |=> (irq_flags & $past(irq_flags)) == $past(irq_flags))
    else $error("flag dropped without a clear");
  // Writing ones keeps every flag
  chk_write_ones: assert property (@(posedge ref_clk) disable iff (!resetn)
    wr_src && reg_wdata == 8'hFF |=> (irq_flags & $past(irq_flags)) == $past(irq_flags))
    else $error("write of ones cleared a flag");
  // Ring end raises the flag only in two-interrupt mode
  chk_ring_end: assert property (@(posedge ref_clk) disable iff (!resetn)
    ring_irq_mode && ring_indicator ##1 !ring_indicator |-> irq_flags[`DIHC_BIT_RING])
    else $error("ring end flag missing");
  // Ring start raises the flag with the indicator
  chk_ring_start: assert property (@(posedge ref_clk) disable iff (!resetn)
    $rose(ring_indicator) |-> irq_flags[`DIHC_BIT_RING])
    else $error("ring start flag missing");
  // Clearing overload pulses the mirror clear
  chk_ovl_mirror: assert property (@(posedge ref_clk) disable iff (!resetn)
    wr_src && !reg_wdata[`DIHC_BIT_RX_OVL] |=> rx_overload_status_clear)
    else $error("overload mirror not cleared");
  // Lost lock keeps frame flag set
  chk_frame_lock: assert property (@(posedge ref_clk) disable iff (!resetn)
    !lock_s |=> irq_flags[`DIHC_BIT_FRAME])
    else $error("frame lock flag missing");
  // Polarity toggle sets its flag one clock later
  chk_polarity_flip: assert property (@(posedge ref_clk) disable iff (!resetn)
    $changed(lvs_msb_s) |=> irq_flags[`DIHC_BIT_POLARITY])
    else $error("polarity flag missing");
  // Pin follows the masked flags with the selected polarity
  chk_irq_pin: assert property (@(posedge ref_clk) disable iff (!resetn)
    ##1 irq_output_pin == ($past(irq_polarity_select) ~^
      ($past(global_irq_enable) && |(irq_flags & $past(irq_mask)))))
    else $error("interrupt pin wrong");
  // Off-hook drops the ring indicator at once
  chk_ring_offhook: assert property (@(posedge ref_clk) disable iff (!resetn)
    $rose(offhook_control) |-> !ring_indicator)
    else $error("ring indicator survived off-hook");
  // Watchdog expiry returns the line on-hook
  chk_watchdog_hook: assert property (@(posedge ref_clk) disable iff (!resetn)
    watchdog_expired |=> !offhook_control [*1])
    else $error("watchdog left line off-hook");
  // Monitor bit takes the written value
  chk_onhook_mon: assert property (@(posedge ref_clk) disable iff (!resetn)
    wr_ctl |=> onhook_monitor_enable == $past(reg_wdata[`DIHC_CTL_ONHOOK_MONITOR_ENABLE]))
    else $error("monitor bit not stored");

endmodule

// File: hdl/dihc_map.svh
/*
  Register offsets, bit positions, reset values and timing figures of the
  interrupt source and line control block.
  Assumes inclusion by bare name from the block's design files.
*/
`ifndef DIHC_MAP_SVH
`define DIHC_MAP_SVH

// Register offsets on the host register port
`define DIHC_REG_IRQ_SRC    8'h04
`define DIHC_REG_LINE_CTL   8'h05

// Reset values
`define DIHC_IRQ_SRC_RESET  8'h00
`define DIHC_LINE_CTL_RESET 8'h00

// Interrupt source flag positions
`define DIHC_BIT_RING       7
`define DIHC_BIT_RX_OVL     6
`define DIHC_BIT_FRAME      5
`define DIHC_BIT_BILLING    4
`define DIHC_BIT_DROPOUT    3
`define DIHC_BIT_LOOP_SAT   2
`define DIHC_BIT_TIP_GND    1
`define DIHC_BIT_POLARITY   0

// Line control field positions
`define DIHC_CTL_RING_NEG   6
`define DIHC_CTL_RING_POS   5
`define DIHC_CTL_ONHOOK_MONITOR_ENABLE       3
`define DIHC_CTL_RING_IND   2
`define DIHC_CTL_OFFHOOK    0

// Loop current reading at saturation
`define DIHC_LOOP_MAX       5'h1F

// Ring indicator hold time and clock rate
`define DIHC_RING_HOLD_S    5
`define DIHC_CLK_HZ         100000000

`endif

// File: hdl/dihc_pkg.sv
/*
  Types of the interrupt source and line control block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package dihc_pkg;

  // One register byte
  typedef logic [7:0] dihc_byte_t;

  // Ring indicator states
  typedef enum logic [0:0]
  {
    DIHC_RI_IDLE    = 1'b0,
    DIHC_RI_RINGING = 1'b1
  } dihc_ring_state_t;

endpackage

// File: hdl/dihc_sync.sv
/*
  Two-flop synchroniser for a vector of slow line-side levels.
  Assumes each bit changes slowly against ref_clk; bits are not coherent.
*/
`timescale 1ns/1ps

module dihc_sync
#(
  parameter int                WIDTH     = 1,
  parameter logic [WIDTH-1:0]  RESET_VAL = '0
)
(
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             resetn,
  // Levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage_one;

  // First stage read only by the second
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      stage_one <= RESET_VAL;
      sync_out  <= RESET_VAL;
    end
    else
    begin
      stage_one <= async_in;
      sync_out  <= stage_one;
    end
  end

endmodule

// File: tb/dihc_line_model.sv
/*
  Line-side device model: raises one commanded line condition for a set
  number of cycles, then drops it again; event 0 flips the voltage sign and leaves it flipped.
  Assumes commands come from the bench on ref_clk.
*/
`timescale 1ns/1ps

module dihc_line_model
(
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  // Event command
  input  wire logic [3:0] event_sel,
  input  wire logic       event_go,
  input  wire logic [7:0] event_len,
  // Line levels
  output logic            ring_positive_in,
  output logic            ring_negative_in,
  output logic            rx_overload_in,
  output logic            frame_lock_in,
  output logic            billing_tone_in,
  output logic            dropout_status_in,
  output logic            tip_ground_status_in,
  output logic            line_voltage_msb_in,
  output logic [4:0]      loop_current_reading_in
);
  logic [7:0] left;
  logic [3:0] sel;
  logic [3:0] wander;
  logic       volt;
  logic       active;

  assign active = left != 8'h00;

  // Event timer, voltage sign and a loop reading that never idles still
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      left   <= 8'h00;
      sel    <= 4'h0;
      volt   <= 1'b0;
      wander <= 4'h0;
    end
    else
    begin
      wander <= wander + 4'h3;
      left   <= event_go ? event_len : left - {7'h00, active};
      sel    <= event_go ? event_sel : sel;
      volt   <= volt ^ (event_go && event_sel == 4'h0);
    end
  end

  // Levels follow the running event; lock and tip status idle high
  assign ring_positive_in        = active && sel == 4'h7;
  assign ring_negative_in        = active && sel == 4'h8;
  assign rx_overload_in          = active && sel == 4'h6;
  assign frame_lock_in           = !(active && sel == 4'h5);
  assign billing_tone_in         = active && sel == 4'h4;
  assign dropout_status_in       = active && sel == 4'h3;
  assign tip_ground_status_in    = !(active && sel == 4'h1);
  assign line_voltage_msb_in     = volt;
  assign loop_current_reading_in = (active && sel == 4'h2) ? 5'h1F : {1'b0, wander};
endmodule

// File: tb/tb.sv
/*
  Self-checking bench for the interrupt source and line control block.
  Assumes the line model on the far side and a shortened ring hold time.
*/
`timescale 1ns/1ps
`include "dihc_map.svh"

module tb;
  logic                 ref_clk, resetn, reg_wr, reg_rd, watchdog_expired, event_go;
  logic                 global_irq_enable, ring_irq_mode, full_wave_ring_enable;
  logic                 irq_polarity_select, clr_seen;
  logic [7:0]           reg_addr, event_len;
  logic [3:0]           event_sel;
  dihc_pkg::dihc_byte_t reg_wdata, reg_rdata, irq_mask, irq_flags, got, exp_flags;
  logic                 ring_positive_in, ring_negative_in, rx_overload_in, frame_lock_in;
  logic                 billing_tone_in, dropout_status_in, tip_ground_status_in;
  logic                 line_voltage_msb_in, irq_output_pin, offhook_control;
  logic                 onhook_monitor_enable, ring_indicator, rx_overload_status_clear;
  logic [4:0]           loop_current_reading_in;
  int                   fail_count, comparisons;

  dihc_top #(.RING_HOLD_CYCLES(50)) dihc_top_inst (.ref_clk, .resetn, .reg_addr, .reg_wr,
    .reg_rd, .reg_wdata, .reg_rdata, .irq_mask, .global_irq_enable, .ring_irq_mode,
    .full_wave_ring_enable, .irq_polarity_select, .watchdog_expired, .ring_positive_in,
    .ring_negative_in, .rx_overload_in, .frame_lock_in, .billing_tone_in, .dropout_status_in,
    .tip_ground_status_in, .line_voltage_msb_in, .loop_current_reading_in, .irq_output_pin,
    .offhook_control, .onhook_monitor_enable, .ring_indicator, .rx_overload_status_clear,
    .irq_flags);

  dihc_line_model dihc_line_model_inst (.ref_clk, .resetn, .event_sel, .event_go, .event_len,
    .ring_positive_in, .ring_negative_in, .rx_overload_in, .frame_lock_in, .billing_tone_in,
    .dropout_status_in, .tip_ground_status_in, .line_voltage_msb_in, .loop_current_reading_in);

  // Compare and count
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
    comparisons++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Register write; also catches the overload clear pulse
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    #1 clr_seen = rx_overload_status_clear;
  endtask

  // Register read, data one cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 got = reg_rdata;
  endtask

  // Start a line event
  task automatic ev(input logic [3:0] s, input logic [7:0] n);
    @(posedge ref_clk);
    event_sel <= s;
    event_len <= n;
    event_go  <= 1'b1;
    @(posedge ref_clk);
    event_go <= 1'b0;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // Expected interrupt pin level
  function automatic logic [7:0] exp_pin(input logic [7:0] f);
    logic act;
    act = |(f & irq_mask) && global_irq_enable;
    return {7'h00, irq_polarity_select ? act : !act};
  endfunction

  task automatic tally_and_finish;
    $display("Comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Clock
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Hang guard, far beyond the roughly 450 cycles of the run
  initial
  begin
    #200000;
    fail_count++;
    tally_and_finish();
  end

  // Main sequence
  initial
  begin
    {resetn, reg_wr, reg_rd, watchdog_expired, event_go, global_irq_enable} = '0;
    {ring_irq_mode, full_wave_ring_enable, irq_polarity_select} = '0;
    {reg_addr, reg_wdata, irq_mask, event_len, event_sel} = '0;
    void'($urandom(32'h659dc274));
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    rd(`DIHC_REG_IRQ_SRC);
    check("flags at reset", 8'h00, got);
    rd(`DIHC_REG_LINE_CTL);
    check("line ctl at reset", 8'h00, got);
    check("idle pin", 8'h01, {7'h00, irq_output_pin});
    // clear ring and dropout after power-up
    wr(`DIHC_REG_IRQ_SRC, 8'h77);
    check("flags after clear", 8'h00, irq_flags);
    $display("Reset test done");
    // Each event flag except ring, random mask, enable and pin polarity
    for (int b = 0; b < 7; b++)
    begin
      @(posedge ref_clk);
      irq_mask            <= 8'($urandom);
      global_irq_enable   <= 1'($urandom);
      irq_polarity_select <= 1'($urandom);
      ev(4'(b), 8'(1 + $urandom % 8));
      idle(14);
      exp_flags = 8'(1 << b);
      check("flag set", exp_flags, irq_flags);
      check("pin set", exp_pin(exp_flags), {7'h00, irq_output_pin});
      rd(`DIHC_REG_IRQ_SRC);
      check("flag read", exp_flags, got);
      wr(`DIHC_REG_IRQ_SRC, 8'hFF);
      check("flag after one", exp_flags, irq_flags);
      wr(8'h03, 8'h00);
      check("flag after other addr", exp_flags, irq_flags);
      wr(`DIHC_REG_IRQ_SRC, ~exp_flags);
      check("overload clear", {7'h00, b == 6}, {7'h00, clr_seen});
      check("flag cleared", 8'h00, irq_flags);
      check("pin cleared", exp_pin(8'h00), {7'h00, irq_output_pin});
    end
    $display("Flag test done");
    // Ring burst in both interrupt modes
    for (int m = 0; m < 2; m++)
    begin
      @(posedge ref_clk);
      ring_irq_mode <= 1'(m);
      ev(4'h7, 8'd20);
      idle(6);
      rd(`DIHC_REG_LINE_CTL);
      check("ring live", 8'h24, got);
      check("ring start flag", 8'h80, irq_flags);
      // start flag cleared before the burst ends
      wr(`DIHC_REG_IRQ_SRC, 8'h7F);
      idle(45);
      check("ring held", 8'h01, {7'h00, ring_indicator});
      idle(40);
      check("ring over", 8'h00, {7'h00, ring_indicator});
      check("ring end flag", 8'(m << 7), irq_flags);
      wr(`DIHC_REG_IRQ_SRC, 8'h00);
    end
    $display("Ring test done");
    // Negative rings with and without full-wave option
    for (int w = 0; w < 2; w++)
    begin
      @(posedge ref_clk);
      full_wave_ring_enable <= 1'(w);
      ev(4'h8, 8'd20);
      idle(6);
      rd(`DIHC_REG_LINE_CTL);
      check("negative ring", w ? 8'h44 : 8'h40, got);
      idle(20);
    end
    wr(`DIHC_REG_LINE_CTL, 8'h09);
    check("off-hook ends ring", 8'h00, {7'h00, ring_indicator});
    check("off-hook", 8'h01, {7'h00, offhook_control});
    check("monitor", 8'h01, {7'h00, onhook_monitor_enable});
    wr(`DIHC_REG_LINE_CTL, 8'hFF);
    rd(`DIHC_REG_LINE_CTL);
    check("read-only bits", 8'h09, got);
    @(posedge ref_clk);
    watchdog_expired <= 1'b1;
    @(posedge ref_clk);
    watchdog_expired <= 1'b0;
    #1;
    check("watchdog on-hook", 8'h00, {7'h00, offhook_control});
    $display("Hook test done");
    tally_and_finish();
  end
endmodule
